// ==== rtl/ptcm_pkg.sv ====
// Constants and types for the per-channel PWM trigger compare block.
// Assumes a 32-bit AXI4-Lite register port and a carrier counter supplied from outside.
//
// Notes on behaviour
// - Mode field bits 2 to 0 of the channel control register; codes 000 and 111 give no trigger at all.
// - Mode 001 fires on a down-count match, 010 on an up-count match and 011 on a match in either direction.
// - Mode 100 fires at the carrier peak, 101 at the bottom and 110 at both peak and bottom.
// - With a sawtooth carrier (waveform select 0), mode 001 acts as an up-count match.
// - With a sawtooth carrier, mode 101 fires at the carrier peak instead of the bottom.
// - Mode 011 with compare value 0x0001 on a triangular carrier gives one trigger per period, not two.
// - The written compare value moves into a second-stage buffer and matching uses that buffer.
// - Control bit 3 selects buffer update: 0 synchronous to the carrier, 1 immediate on every write.
// - While the PWM enable bit is 0 every compare write reaches the buffer at once, whatever bit 3 holds.
// - In synchronous mode the timing select moves the value at bottom (01), peak (10) or either (11).
`default_nettype none
package ptcm_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          CMP_W         = 16;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CMP       = 8'h04;
  localparam logic [7:0]  OFS_PWMMODE   = 8'h08;
  localparam logic [7:0]  OFS_PWMEN     = 8'h0c;
  localparam logic [7:0]  OFS_TSYNC     = 8'h10;
  localparam logic [7:0]  OFS_BUFSTAT   = 8'h14;

  localparam int          MODE_LSB      = 0;
  localparam int          MODE_MSB      = 2;
  localparam int          ASYNC_BIT     = 3;
  localparam int          WAVE_BIT      = 0;
  localparam int          EN_BIT        = 0;
  localparam int          TSYNC_LSB     = 0;
  localparam int          TSYNC_MSB     = 1;

  localparam logic [2:0]  MODE_OFF0     = 3'h0;
  localparam logic [2:0]  MODE_DOWN     = 3'h1;
  localparam logic [2:0]  MODE_UP       = 3'h2;
  localparam logic [2:0]  MODE_BOTH     = 3'h3;
  localparam logic [2:0]  MODE_PEAK     = 3'h4;
  localparam logic [2:0]  MODE_BOTTOM   = 3'h5;
  localparam logic [2:0]  MODE_PKBT     = 3'h6;
  localparam logic [2:0]  MODE_OFF7     = 3'h7;

  localparam logic [1:0]  TSYNC_NOW     = 2'h0;
  localparam logic [1:0]  TSYNC_BOTTOM  = 2'h1;
  localparam logic [1:0]  TSYNC_PEAK    = 2'h2;
  localparam logic [1:0]  TSYNC_EITHER  = 2'h3;

  localparam logic [15:0] CMP_ONE       = 16'h0001;
  localparam logic [15:0] CMP_RST       = 16'h0000;
  localparam logic [2:0]  MODE_RST      = 3'h0;
  localparam logic [1:0]  TSYNC_RST     = 2'h0;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic        peak;
    logic        bottom;
  } ptcm_carrier_t;

endpackage
`default_nettype wire

// ==== rtl/ptcm_trigger.sv ====
// Trigger compare channel 0 with its AXI4-Lite register slave.
// Assumes the carrier counter, its direction and one-cycle peak/bottom strobes arrive synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
module ptcm_trigger
  import ptcm_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire ptcm_carrier_t       carrier,
  output logic                     trig_out
);

  logic [2:0]        mode_r;
  logic              async_r;
  logic [CMP_W-1:0]  cmp_r;
  logic              wave_r;
  logic              en_r;
  logic [1:0]        tsync_r;
  logic [CMP_W-1:0]  buf_r;
  logic              eq_prev_r;
  logic              trig_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              do_write;
  logic              aw_full_nxt;
  logic              w_full_nxt;
  logic              bvalid_nxt;
  logic              rvalid_nxt;
  logic              wr_cmp;
  logic [31:0]       wmerged;
  logic [31:0]       rd_nxt;
  logic              rd_ok;
  logic              wr_ok;
  logic              saw;
  logic              eq;
  logic              hit;
  logic              hit_up;
  logic              hit_down;
  logic              sync_evt;
  logic              trig_nxt;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction
  assign aw_hs    = awvalid && awready_r;
  assign w_hs     = wvalid && wready_r;
  assign ar_hs    = arvalid && arready_r;
  assign do_write = aw_full_r && w_full_r && !bvalid_r;

  // Write path: address and data taken in either order, response after both
  always_comb
  begin
    aw_full_nxt = (aw_full_r && !do_write) || aw_hs;
    w_full_nxt  = (w_full_r && !do_write) || w_hs;
    bvalid_nxt  = do_write || (bvalid_r && !bready);
    rvalid_nxt  = ar_hs || (rvalid_r && !rready);
  end
  always_comb
  begin
    wr_ok   = 1'b1;
    wmerged = 32'h0000_0000;
    unique case (waddr_r)
      OFS_CTRL:    wmerged = merge({28'h000_0000, async_r, mode_r}, wdata_r, wstrb_r);
      OFS_CMP:     wmerged = merge({16'h0000, cmp_r}, wdata_r, wstrb_r);
      OFS_PWMMODE: wmerged = merge({31'h0000_0000, wave_r}, wdata_r, wstrb_r);
      OFS_PWMEN:   wmerged = merge({31'h0000_0000, en_r}, wdata_r, wstrb_r);
      OFS_TSYNC:   wmerged = merge({30'h0000_0000, tsync_r}, wdata_r, wstrb_r);
      default:     wr_ok   = 1'b0;
    endcase
  end
  assign wr_cmp = do_write && (waddr_r == OFS_CMP);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      // Ready drops for the whole write so a second one cannot overtake the response
      awready_r <= !aw_full_nxt && !bvalid_nxt;
      wready_r  <= !w_full_nxt && !bvalid_nxt;
      if (aw_hs)
        waddr_r <= awaddr;
      if (w_hs)
      begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write)
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r  <= MODE_RST;
      async_r <= 1'b0;
      cmp_r   <= CMP_RST;
      wave_r  <= 1'b0;
      en_r    <= 1'b0;
      tsync_r <= TSYNC_RST;
    end
    else if (do_write)
    begin
      unique case (waddr_r)
        OFS_CTRL:
        begin
          mode_r  <= wmerged[MODE_MSB:MODE_LSB];
          async_r <= wmerged[ASYNC_BIT];
        end
        OFS_CMP:     cmp_r   <= wmerged[CMP_W-1:0];
        OFS_PWMMODE: wave_r  <= wmerged[WAVE_BIT];
        OFS_PWMEN:   en_r    <= wmerged[EN_BIT];
        OFS_TSYNC:   tsync_r <= wmerged[TSYNC_MSB:TSYNC_LSB];
        default:     ;
      endcase
    end
  end

  // Read path: answer one cycle after the address is taken
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (araddr)
      OFS_CTRL:    rd_nxt = {28'h000_0000, async_r, mode_r};
      OFS_CMP:     rd_nxt = {16'h0000, cmp_r};
      OFS_PWMMODE: rd_nxt = {31'h0000_0000, wave_r};
      OFS_PWMEN:   rd_nxt = {31'h0000_0000, en_r};
      OFS_TSYNC:   rd_nxt = {30'h0000_0000, tsync_r};
      OFS_BUFSTAT: rd_nxt = {16'h0000, buf_r};
      default:     rd_ok  = 1'b0;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end
    else
    begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= !rvalid_nxt;
      if (ar_hs)
      begin
        rdata_r <= rd_nxt;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  // Compare buffer
  always_comb
  begin
    unique case (tsync_r)
      TSYNC_NOW:    sync_evt = 1'b1;
      TSYNC_BOTTOM: sync_evt = carrier.bottom;
      TSYNC_PEAK:   sync_evt = carrier.peak;
      TSYNC_EITHER: sync_evt = carrier.peak || carrier.bottom;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      buf_r <= CMP_RST;
    else if (wr_cmp && (async_r || !en_r))
      buf_r <= wmerged[CMP_W-1:0];
    else if (en_r && !async_r && sync_evt)
      buf_r <= cmp_r;
  end
  // Match detection on the buffered copy; edge of equality so a held count fires once
  assign saw      = !wave_r;
  assign eq       = carrier.count == buf_r;
  assign hit      = eq && !eq_prev_r;
  assign hit_up   = hit && (saw || !carrier.down);
  assign hit_down = hit && !saw && carrier.down;
  always_comb
  begin
    unique case (mode_r)
      MODE_DOWN:   trig_nxt = saw ? hit_up : hit_down;
      MODE_UP:     trig_nxt = hit_up;
      // At 0x0001 the up match sits right after the down match across the bottom
      MODE_BOTH:   trig_nxt = hit_down || (hit_up && !(!saw && buf_r == CMP_ONE));
      MODE_PEAK:   trig_nxt = carrier.peak;
      MODE_BOTTOM: trig_nxt = saw ? carrier.peak : carrier.bottom;
      MODE_PKBT:   trig_nxt = carrier.peak || carrier.bottom;
      default:     trig_nxt = 1'b0;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eq_prev_r <= 1'b0;
      trig_r    <= 1'b0;
    end
    else
    begin
      eq_prev_r <= eq;
      trig_r    <= trig_nxt;
    end
  end
  assign awready  = awready_r;
  assign wready   = wready_r;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign arready  = arready_r;
  assign rvalid   = rvalid_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;
  assign trig_out = trig_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sync_bottom;
    en_r && !async_r && tsync_r == TSYNC_BOTTOM && carrier.bottom;
  endsequence

  a_mode_off_quiet:  assert property ((mode_r == MODE_OFF0 || mode_r == MODE_OFF7) |=> !trig_r)
    else $error("trigger fired with mode off");
  a_down_match_fire: assert property ((mode_r == MODE_DOWN && !saw && hit_down) |=> trig_r)
    else $error("down-count match gave no trigger");
  a_up_match_fire:   assert property ((mode_r == MODE_UP && hit && (saw || !carrier.down)) |=> trig_r)
    else $error("up-count match gave no trigger");
  a_peak_event_fire: assert property ((mode_r == MODE_PEAK && carrier.peak) |=> trig_r)
    else $error("peak gave no trigger");
  a_saw_down_alias:  assert property ((mode_r == MODE_DOWN && saw && hit) |=> trig_r)
    else $error("sawtooth mode 001 missed up match");
  a_saw_bottom_peak: assert property ((mode_r == MODE_BOTTOM && saw) |=> trig_r == $past(carrier.peak))
    else $error("sawtooth mode 101 not on peak");
  a_one_per_period:  assert property ((mode_r == MODE_BOTH && !saw && buf_r == CMP_ONE && hit)
                                      && !carrier.down |=> !trig_r)
    else $error("second trigger at compare 0x0001");
  a_buf_immediate:   assert property ((wr_cmp && (async_r || !en_r)) |=> buf_r == cmp_r)
    else $error("immediate buffer update missed");
  a_buf_sync_take:   assert property (s_sync_bottom |=> buf_r == $past(cmp_r))
    else $error("buffer not loaded at bottom");
  a_buf_sync_hold:   assert property ((en_r && !async_r && tsync_r == TSYNC_BOTTOM)
                                      && !carrier.bottom |=> $stable(buf_r))
    else $error("buffer changed outside its update point");
  a_trig_one_cycle:  assert property ((trig_r && mode_r == MODE_UP) |=> !trig_r)
    else $error("match trigger longer than one cycle");

endmodule
`default_nettype wire

// ==== test/ptcm_carrier_model.sv ====
// Carrier counter source and trigger sink for the trigger compare channel.
// Assumes it shares aclk and aresetn with the block; the carrier stands still while run is low.
`timescale 1ns/10ps
`default_nettype none
module ptcm_carrier_model
  import ptcm_pkg::*;
#(
  parameter logic [15:0] TOP = 16'h0008
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          run,
  input  wire logic          tri_wave,
  input  wire logic          clr,
  input  wire logic          trig_out,
  output var ptcm_carrier_t  carrier,
  output var logic [7:0]     n_up,
  output var logic [7:0]     n_dn,
  output var logic [7:0]     n_pk,
  output var logic [7:0]     n_bt
);
  logic [15:0]   cnt_r;
  logic          dir_r;
  ptcm_carrier_t prev_r;

  // Strobes only while running, so a frozen carrier gives no stray events
  assign carrier = '{count: cnt_r, down: dir_r, peak: run && cnt_r == TOP, bottom: run && cnt_r == 16'h0000};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 16'h0000;
      dir_r <= 1'b0;
    end
    else if (run && tri_wave)
    begin
      cnt_r <= dir_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      if (!dir_r && cnt_r >= TOP - 16'h0001) dir_r <= 1'b1;
      if (dir_r && cnt_r == 16'h0001) dir_r <= 1'b0;
    end
    else if (run)
    begin
      cnt_r <= (cnt_r == TOP) ? 16'h0000 : cnt_r + 16'h0001;
      dir_r <= 1'b0;
    end
  end

  // Each pulse is filed under the carrier event seen one edge earlier
  always_ff @(posedge aclk)
  begin
    prev_r <= carrier;
    if (clr)
    begin
      n_up <= 8'h00;
      n_dn <= 8'h00;
      n_pk <= 8'h00;
      n_bt <= 8'h00;
    end
    else if (trig_out)
    begin
      if (prev_r.peak) n_pk <= n_pk + 8'h01;
      else if (prev_r.bottom) n_bt <= n_bt + 8'h01;
      else if (prev_r.down) n_dn <= n_dn + 8'h01;
      else n_up <= n_up + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== test/ptcm_trigger_tb_top.sv ====
// Self-checking bench for the trigger compare channel and its register port.
// Assumes the carrier model file and the design package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module ptcm_trigger_tb_top
  import ptcm_pkg::*;
;
  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run, tri_wave, clr;
  logic          awready, wready, bvalid, arready, rvalid, trig_out;
  logic [7:0]    awaddr, araddr, n_up, n_dn, n_pk, n_bt;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp;
  ptcm_carrier_t carrier;
  int            miscompares, compares;

  ptcm_trigger u_ptcm_trigger (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .carrier, .trig_out);
  ptcm_carrier_model u_ptcm_carrier_model (.aclk, .aresetn, .run, .tri_wave, .clr, .trig_out, .carrier,
    .n_up, .n_dn, .n_pk, .n_bt);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Every wait is bounded; running out ends the run
  task automatic guard(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100)
    begin
      miscompares++;
      $display("wrong value at %0t: bus wait ran out", $time);
      end_sim;
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      guard(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do
      guard(n);
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      guard(n);
    while (!arready);
    arvalid <= 1'b0;
    do
      guard(n);
    while (!rvalid);
    chk(rdata, e, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  task automatic test_regs;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
      rchk(8'(i * 4), 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'hffffffff);
    rchk(OFS_CTRL, 32'h0000000f, RESP_OKAY);
    axw(8'h20, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axw(OFS_BUFSTAT, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "buffer write");
    rchk(8'h20, 32'h0, RESP_SLVERR);
    $display("test regs done");
  endtask

  // Counts land in bytes {up, down, peak, bottom} over three whole carrier periods
  task automatic trig_case(input logic [2:0] m, input logic w, input logic [15:0] c, input logic [31:0] e);
    int per;
    per = w ? 16 : 9;
    tri_wave <= w;
    wr(OFS_PWMMODE, {31'h0, w});
    wr(OFS_CMP, {16'h0, c});
    wr(OFS_CTRL, {28'h0, 1'b1, m});
    repeat (2 * per) @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (3 * per) @(posedge aclk);
    @(negedge aclk);
    chk({n_up, n_dn, n_pk, n_bt}, e, "trigger counts");
    @(posedge aclk);
  endtask

  task automatic test_modes;
    trig_case(MODE_OFF0, 1'b1, 16'h0004, 32'h00000000);
    trig_case(MODE_DOWN, 1'b1, 16'h0004, 32'h00030000);
    trig_case(MODE_UP, 1'b1, 16'h0004, 32'h03000000);
    trig_case(MODE_BOTH, 1'b1, 16'h0004, 32'h03030000);
    trig_case(MODE_PEAK, 1'b1, 16'h0004, 32'h00000300);
    trig_case(MODE_BOTTOM, 1'b1, 16'h0004, 32'h00000003);
    trig_case(MODE_PKBT, 1'b1, 16'h0004, 32'h00000303);
    trig_case(MODE_OFF7, 1'b1, 16'h0004, 32'h00000000);
    trig_case(MODE_DOWN, 1'b0, 16'h0004, 32'h03000000);
    trig_case(MODE_BOTTOM, 1'b0, 16'h0004, 32'h00000300);
    trig_case(MODE_BOTH, 1'b1, CMP_ONE, 32'h00030000);
    $display("test modes done");
  endtask

  // Carrier is frozen around each write after the PWM enable write so no update event can sneak in
  task automatic test_buffer;
    logic [31:0] old;
    old = 32'h00000001;
    wr(OFS_CTRL, {29'h0, MODE_UP});
    wr(OFS_PWMEN, 32'h1);
    for (int t = 1; t < 4; t++)
    begin
      run <= 1'b0;
      wr(OFS_TSYNC, 32'(t));
      wr(OFS_CMP, 32'(16'h0100 + t));
      rchk(OFS_BUFSTAT, old, RESP_OKAY);
      run <= 1'b1;
      repeat (17) @(posedge aclk);
      run <= 1'b0;
      old = 32'(16'h0100 + t);
      rchk(OFS_BUFSTAT, old, RESP_OKAY);
    end
    wr(OFS_CTRL, {28'h0, 1'b1, MODE_UP});
    wr(OFS_CMP, 32'h0055);
    rchk(OFS_BUFSTAT, 32'h0055, RESP_OKAY);
    wr(OFS_CTRL, {29'h0, MODE_UP});
    wr(OFS_PWMEN, 32'h0);
    wr(OFS_CMP, 32'h0066);
    rchk(OFS_BUFSTAT, 32'h0066, RESP_OKAY);
    $display("test buffer done");
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, run, clr} = 7'h00;
    tri_wave = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    test_regs;
    test_modes;
    test_buffer;
    end_sim;
  end
endmodule
`default_nettype wire
